// ---- dv/cib_peer.sv ----
/* Interconnect stand-in: accepts messages, reports sync completion.
 Assumes the bench picks the acceptance lag. */
`timescale 1ns/100ps
`default_nettype none
module cib_peer
(
  input wire logic mclk,
  input wire logic [1:0] lag,
  input wire logic msg_valid,
  input wire logic [2:0] msg_kind,
  output logic msg_ready,
  output logic sync_complete
);
  int cnt = 0;
  int sc = 0;
  initial msg_ready = 1'b0;
  initial sync_complete = 1'b0;
  always @(negedge mclk)
  begin
    cnt = msg_valid ? cnt + 1 : 0;
    msg_ready <= msg_valid && cnt > lag;
    sync_complete <= (sc == 1);
    if (sc != 0) sc = sc - 1;
  end
  // Peers need a few cycles to finish after the sync
  always @(posedge mclk)
  begin
    if (msg_valid && msg_ready && msg_kind == 3'h6) sc = 4;
  end
endmodule // cib_peer
`default_nettype wire

// ---- dv/cib_top_asserts.sv ----
/* Port checker for cib_top.
 Assumes only the top ports; bound at the foot. */
`timescale 1ns/100ps
`default_nettype none
`include "cib_defines.svh"
module cib_top_asserts
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic DC_FLUSH_REQ,
  input wire logic DC_CLEAR_REQ,
  input wire logic [`CIB_ADDR_W-1:0] DC_PADDR,
  input wire logic LOCAL_BUSY,
  input wire logic MEMORY_BARRIER_INSTR_DONE,
  input wire logic COHERENT,
  input wire logic MSG_VALID,
  input wire logic [`CIB_KIND_W-1:0] MSG_KIND,
  input wire logic [`CIB_ADDR_W-1:0] MSG_ADDR,
  input wire logic MSG_READY,
  input wire logic SYNC_COMPLETE,
  input wire logic [`CIB_KIND_W-1:0] RX_KIND,
  input wire logic LOC_DC_INV,
  input wire logic LOC_IC_INV,
  input wire logic RESP_VALID,
  input wire logic LOC_ACK
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  wire logic idle = COHERENT && !LOCAL_BUSY && !MSG_VALID;
  property p_hold;
    MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG_KIND) && $stable(MSG_ADDR);
  endproperty
  a_hold: assert property (p_hold) else $error("message moved early");
  property p_nocoh;
    !COHERENT |-> !MSG_VALID && !LOC_DC_INV;
  endproperty
  a_nocoh: assert property (p_nocoh) else $error("traffic while off");
  property p_flush;
    idle && DC_FLUSH_REQ |=> MSG_VALID && MSG_KIND == 3'h0 && MSG_ADDR == $past(DC_PADDR);
  endproperty
  a_flush: assert property (p_flush) else $error("bad flush message");
  property p_clear;
    idle && DC_CLEAR_REQ && !DC_FLUSH_REQ |=> MSG_KIND == 3'h1 && MSG_ADDR == $past(DC_PADDR);
  endproperty
  a_clear: assert property (p_clear) else $error("bad clear message");
  property p_coh;
    COHERENT |=> COHERENT [*4];
  endproperty
  a_coh: assert property (p_coh) else $error("coherency dropped");
  property p_rxdc;
    $rose(LOC_DC_INV) |-> $past(RX_KIND) < 3'h2 && !LOC_IC_INV;
  endproperty
  a_rxdc: assert property (p_rxdc) else $error("bad data cache strobe");
  property p_resp;
    $rose(RESP_VALID) |-> $past(LOC_ACK);
  endproperty
  a_resp: assert property (p_resp) else $error("response before apply");
  property p_memory_barrier_instr;
    MEMORY_BARRIER_INSTR_DONE && COHERENT |-> $past(SYNC_COMPLETE);
  endproperty
  a_memory_barrier_instr: assert property (p_memory_barrier_instr) else $error("barrier done early");
  c_memory_barrier_instr: cover property (MEMORY_BARRIER_INSTR_DONE);
  c_stall: cover property (MSG_VALID && !MSG_READY);
  c_rx: cover property (LOC_DC_INV && LOC_ACK);
endmodule // cib_top_asserts
bind cib_top cib_top_asserts u_chk (.MCLK(MCLK), .RESET_N(RESET_N),
  .DC_FLUSH_REQ(DC_FLUSH_REQ), .DC_CLEAR_REQ(DC_CLEAR_REQ), .DC_PADDR(DC_PADDR),
  .LOCAL_BUSY(LOCAL_BUSY), .MEMORY_BARRIER_INSTR_DONE(MEMORY_BARRIER_INSTR_DONE), .COHERENT(COHERENT),
  .MSG_VALID(MSG_VALID), .MSG_KIND(MSG_KIND), .MSG_ADDR(MSG_ADDR),
  .MSG_READY(MSG_READY), .SYNC_COMPLETE(SYNC_COMPLETE), .RX_KIND(RX_KIND),
  .LOC_DC_INV(LOC_DC_INV), .LOC_IC_INV(LOC_IC_INV), .RESP_VALID(RESP_VALID),
  .LOC_ACK(LOC_ACK));
`default_nettype wire

// ---- dv/tb.sv ----
/* Bench for cib_top: reset, outbound table, inbound kinds.
 Assumes cib_peer stands in for the interconnect. */
`timescale 1ns/100ps
`default_nettype none
`include "cib_defines.svh"
module tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] req = 6'h00;
  logic mmu = 1'b0;
  logic tlbv = 1'b0;
  logic [31:0] a = 32'h0;
  logic [1:0] lag = 2'h0;
  logic rx_valid = 1'b0;
  logic [2:0] rx_kind = 3'h0;
  logic resp_ready = 1'b0;
  logic loc_ack = 1'b0;
  logic busy, done, coh, mv, mr, sc, rx_ready, rv, ldc, lic, ltlb, lbtc;
  logic [2:0] mk, ek, k;
  logic [31:0] ma, la;
  int fails = 0;
  int samples_checked = 0;
  int i, s;
  // Row: flush clear ic tlb sync memory_barrier_instr, mmu virtual, tlb valid, kind (7 none)
  logic [10:0] rows [9] = '{11'h500, 11'h201, 11'h600, 11'h104, 11'h115,
    11'h082, 11'h08f, 11'h043, 11'h023};
  logic [3:0] strobe [7] = '{4'h1, 4'h1, 4'h4, 4'h8, 4'h2, 4'h2, 4'h0};
  always #10 mclk = ~mclk;
  cib_top dut (.MCLK(mclk), .RESET_N(reset_n), .DC_FLUSH_REQ(req[5]),
    .DC_CLEAR_REQ(req[4]), .DC_PADDR(a), .IC_INV_REQ(req[3]), .MMU_VIRTUAL(mmu),
    .IC_VADDR(~a), .IC_PADDR(a ^ 32'h0f0f0000), .TRANSLATION_HIGH_REG_WRITE(req[2]), .TRANSLATION_HIGH_REG_VALID(tlbv),
    .TRANSLATION_HIGH_REG_VADDR({a[15:0], a[31:16]}), .SYNC_BRANCH_REQ(req[1]), .MEMORY_BARRIER_INSTR_REQ(req[0]),
    .LOCAL_BUSY(busy), .MEMORY_BARRIER_INSTR_DONE(done), .COHERENT(coh), .MSG_VALID(mv), .MSG_KIND(mk),
    .MSG_ADDR(ma), .MSG_READY(mr), .SYNC_COMPLETE(sc), .RX_VALID(rx_valid),
    .RX_KIND(rx_kind), .RX_ADDR(a), .RX_READY(rx_ready), .RESP_VALID(rv),
    .RESP_READY(resp_ready), .LOC_DC_INV(ldc), .LOC_IC_INV(lic), .LOC_TLB_INV(ltlb),
    .LOC_BTC_INV(lbtc), .LOC_INV_ADDR(la), .LOC_ACK(loc_ack));
  cib_peer peer (.mclk(mclk), .lag(lag), .msg_valid(mv), .msg_kind(mk), .msg_ready(mr),
    .sync_complete(sc));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bounded wait: 0 message, 1 message gone, 2 barrier done, 3 response
  task automatic wait_on(input int w);
    for (int n = 0; n < 40; n++)
    begin
      if (w == 0 && mv === 1'b1 || w == 1 && !(mv === 1'b1 && mk === ek) ||
          w == 2 && done === 1'b1 || w == 3 && rv === 1'b1)
        return;
      @(posedge mclk);
      #1;
    end
    fails++;
    tally_and_finish();
  endtask
  task automatic expect_msg(input logic [2:0] kk);
    ek = kk;
    wait_on(0);
    chk({29'h0, mk}, {29'h0, kk});
    case (kk)
      3'h2: chk(ma, {a[15:0], a[31:16]});
      3'h4: chk(ma, a ^ 32'h0f0f0000);
      3'h5: chk(ma, ~a);
      3'h0, 3'h1: chk(ma, a);
      default: ;
    endcase
    @(negedge mclk);
    req = 6'h00;
    wait_on(1);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    #1 chk({31'h0, mv | coh}, 32'h0);
    @(negedge mclk);
    reset_n = 1'b1;
    @(posedge mclk);
    #1 chk({31'h0, coh}, 32'h0);
    @(posedge mclk);
    #1 chk({31'h0, coh}, 32'h1);
    for (s = 0; s < 2; s++)
    begin
      lag = s[0] ? 2'h3 : 2'h0;
      for (i = 0; i < 9; i++)
      begin
        @(negedge mclk);
        // Page is assumed already loaded before each invalidate
        {req, mmu, tlbv} = rows[i][10:3];
        k = rows[i][2:0];
        a = 32'h12345640 + 32'(i) * 32'h104;
        if (k == 3'h7)
        begin
          repeat (4) @(posedge mclk);
          #1 chk({31'h0, mv}, 32'h0);
          req = 6'h00;
        end
        else
        begin
          expect_msg(k);
          if (rows[i][5])
          begin
            expect_msg(3'h6);
            wait_on(2);
          end
        end
      end
    end
    for (i = 0; i < 7; i++)
    begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_kind = i[2:0];
      a = 32'h00abcd00 + 32'(i);
      @(negedge mclk);
      rx_valid = 1'b0;
      @(posedge mclk);
      #1 chk({28'h0, lbtc, ltlb, lic, ldc}, {28'h0, strobe[i]});
      if (i < 6) chk(la, a);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, rv}, 32'h0);
      @(negedge mclk);
      loc_ack = 1'b1;
      @(negedge mclk);
      loc_ack = 1'b0;
      wait_on(3);
      chk({28'h0, lbtc, ltlb, lic, ldc}, 32'h0);
      @(negedge mclk);
      resp_ready = 1'b1;
      @(negedge mclk);
      resp_ready = 1'b0;
    end
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire

// ---- rtl/cib_defines.svh ----
/*
 Constants for the coherent invalidation broadcast block: message kinds,
 configuration values and address width. Assumes inclusion by bare name.
*/
`ifndef CIB_DEFINES_SVH
`define CIB_DEFINES_SVH

`define CIB_ADDR_W 32
`define CIB_KIND_W 3
`define CIB_SEL_COHERENT 3
`define CIB_DATA_W_MAX 32
`define CIB_FORCED_ON 1
`define CIB_KIND_CLEAN_INV 3'h0
`define CIB_KIND_MAKE_INV 3'h1
`define CIB_KIND_TLB_INV 3'h2
`define CIB_KIND_BTC_INV 3'h3
`define CIB_KIND_IC_INV_PA 3'h4
`define CIB_KIND_IC_INV_VA 3'h5
`define CIB_KIND_SYNC 3'h6

`endif

// ---- rtl/cib_pkg.sv ----
/*
 Types shared by the broadcast block and its inbound applier.
 Assumes cib_defines.svh is on the include path.
*/
`include "cib_defines.svh"

package cib_pkg;
  typedef logic [`CIB_KIND_W-1:0] cib_kind_t;
  typedef logic [`CIB_ADDR_W-1:0] cib_addr_t;
  typedef enum logic [1:0]
  {
    CIB_TX_IDLE = 2'b00,
    CIB_TX_SEND = 2'b01,
    CIB_TX_SYNC = 2'b10,
    CIB_TX_WAIT = 2'b11
  } cib_tx_e;
  typedef enum logic [1:0]
  {
    CIB_RX_IDLE = 2'b00,
    CIB_RX_APPLY = 2'b01,
    CIB_RX_RESP = 2'b10
  } cib_rx_e;
endpackage

// ---- rtl/cib_rx.sv ----
/*
 Applies invalidations received from peer cores to the local structures,
 then answers the interconnect. Assumes the local structures acknowledge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cib_defines.svh"

module cib_rx
(
  input wire logic mclk,
  input wire logic reset_n,
  cib_rx_if.applier port
);
  cib_pkg::cib_rx_e state;

  // One message in flight; ready only while idle
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      state <= cib_pkg::CIB_RX_IDLE;
    else
      case (state)
        cib_pkg::CIB_RX_IDLE:
          if (port.enable && port.rx_valid)
            state <= cib_pkg::CIB_RX_APPLY;
        cib_pkg::CIB_RX_APPLY:
          if (port.loc_ack)
            state <= cib_pkg::CIB_RX_RESP;
        cib_pkg::CIB_RX_RESP:
          if (port.resp_ready)
            state <= cib_pkg::CIB_RX_IDLE;
        default:
          state <= cib_pkg::CIB_RX_IDLE;
      endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      port.rx_ready <= 1'b0;
    else
      port.rx_ready <= port.enable && state == cib_pkg::CIB_RX_IDLE && !port.rx_valid;
  end

  // Strobes raised on take, held until the local ack
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      port.dc_inv <= 1'b0;
      port.ic_inv <= 1'b0;
      port.tlb_inv <= 1'b0;
      port.btc_inv <= 1'b0;
      port.inv_addr <= '0;
    end
    else if (state == cib_pkg::CIB_RX_IDLE && port.enable && port.rx_valid)
    begin
      port.inv_addr <= port.rx_addr;
      // Clean and make invalid touch only the data cache
      port.dc_inv <= port.rx_kind == `CIB_KIND_CLEAN_INV
        || port.rx_kind == `CIB_KIND_MAKE_INV;
      port.ic_inv <= port.rx_kind == `CIB_KIND_IC_INV_PA
        || port.rx_kind == `CIB_KIND_IC_INV_VA;
      // TLB match ignores the process id; later misses trap to software
      port.tlb_inv <= port.rx_kind == `CIB_KIND_TLB_INV;
      port.btc_inv <= port.rx_kind == `CIB_KIND_BTC_INV;
    end
    else if (port.loc_ack)
    begin
      port.dc_inv <= 1'b0;
      port.ic_inv <= 1'b0;
      port.tlb_inv <= 1'b0;
      port.btc_inv <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      port.resp_valid <= 1'b0;
    else if (state == cib_pkg::CIB_RX_APPLY && port.loc_ack)
      port.resp_valid <= 1'b1;
    else if (port.resp_ready)
      port.resp_valid <= 1'b0;
  end
endmodule // cib_rx

`default_nettype wire

// ---- rtl/cib_rx_if.sv ----
/*
 Carrier between the top block and the inbound invalidation applier.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface cib_rx_if;
  logic enable;
  logic rx_valid;
  cib_pkg::cib_kind_t rx_kind;
  cib_pkg::cib_addr_t rx_addr;
  logic rx_ready;
  logic dc_inv;
  logic ic_inv;
  logic tlb_inv;
  logic btc_inv;
  cib_pkg::cib_addr_t inv_addr;
  logic loc_ack;
  logic resp_valid;
  logic resp_ready;
  modport top
  (
    output enable, rx_valid, rx_kind, rx_addr, loc_ack, resp_ready,
    input rx_ready, dc_inv, ic_inv, tlb_inv, btc_inv, inv_addr, resp_valid
  );
  modport applier
  (
    input enable, rx_valid, rx_kind, rx_addr, loc_ack, resp_ready,
    output rx_ready, dc_inv, ic_inv, tlb_inv, btc_inv, inv_addr, resp_valid
  );
endinterface

`default_nettype wire

// ---- rtl/cib_top.sv ----
/*
 Coherent invalidation broadcast: spreads local cache, TLB and branch
 target invalidations to peer cores and applies those of peers.
 Assumes one core clock, inputs synchronous to it, and an interconnect
 that reports when all peers finished a synchronisation.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cib_defines.svh"

module cib_top
#(
  parameter int INTERCONNECT_SELECT_PARAM = `CIB_SEL_COHERENT,
  parameter int INSTR_CACHE_FORCED_ON_PARAM = `CIB_FORCED_ON,
  parameter int DATA_CACHE_FORCED_ON_PARAM = `CIB_FORCED_ON,
  parameter int DCACHE_WRITEBACK = 0,
  parameter int CACHE_DATA_WIDTH = `CIB_DATA_W_MAX,
  parameter int ICACHE_STREAMS = 0,
  parameter int ICACHE_VICTIMS = 0,
  parameter int AREA_OPTIMIZED = 0
)
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic DC_FLUSH_REQ,
  input wire logic DC_CLEAR_REQ,
  input wire logic [`CIB_ADDR_W-1:0] DC_PADDR,
  input wire logic IC_INV_REQ,
  input wire logic MMU_VIRTUAL,
  input wire logic [`CIB_ADDR_W-1:0] IC_VADDR,
  input wire logic [`CIB_ADDR_W-1:0] IC_PADDR,
  input wire logic TRANSLATION_HIGH_REG_WRITE,
  input wire logic TRANSLATION_HIGH_REG_VALID,
  input wire logic [`CIB_ADDR_W-1:0] TRANSLATION_HIGH_REG_VADDR,
  input wire logic SYNC_BRANCH_REQ,
  input wire logic MEMORY_BARRIER_INSTR_REQ,
  output logic LOCAL_BUSY,
  output logic MEMORY_BARRIER_INSTR_DONE,
  output logic COHERENT,
  output logic MSG_VALID,
  output logic [`CIB_KIND_W-1:0] MSG_KIND,
  output logic [`CIB_ADDR_W-1:0] MSG_ADDR,
  input wire logic MSG_READY,
  input wire logic SYNC_COMPLETE,
  input wire logic RX_VALID,
  input wire logic [`CIB_KIND_W-1:0] RX_KIND,
  input wire logic [`CIB_ADDR_W-1:0] RX_ADDR,
  output logic RX_READY,
  output logic RESP_VALID,
  input wire logic RESP_READY,
  output logic LOC_DC_INV,
  output logic LOC_IC_INV,
  output logic LOC_TLB_INV,
  output logic LOC_BTC_INV,
  output logic [`CIB_ADDR_W-1:0] LOC_INV_ADDR,
  input wire logic LOC_ACK
);
  // Peripheral and local memory traffic never reaches this block
  localparam bit COH_ON = INTERCONNECT_SELECT_PARAM == `CIB_SEL_COHERENT
    && INSTR_CACHE_FORCED_ON_PARAM == `CIB_FORCED_ON
    && DATA_CACHE_FORCED_ON_PARAM == `CIB_FORCED_ON
    && DCACHE_WRITEBACK == 0 && CACHE_DATA_WIDTH <= `CIB_DATA_W_MAX
    && ICACHE_STREAMS == 0 && ICACHE_VICTIMS == 0 && AREA_OPTIMIZED == 0;

  cib_pkg::cib_tx_e state;
  logic take;
  logic tlb_inv_req;
  logic barrier;
  logic coherent;

  cib_rx_if rx_port ();

  assign tlb_inv_req = TRANSLATION_HIGH_REG_WRITE && !TRANSLATION_HIGH_REG_VALID;
  assign take = COHERENT && state == cib_pkg::CIB_TX_IDLE
    && (DC_FLUSH_REQ || DC_CLEAR_REQ || IC_INV_REQ || tlb_inv_req
    || SYNC_BRANCH_REQ || MEMORY_BARRIER_INSTR_REQ);

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      coherent <= 1'b0;
    else
      coherent <= COH_ON;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      COHERENT <= 1'b0;
    else
      COHERENT <= coherent;
  end

  // Local kind and address chosen by fixed priority
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      MSG_KIND <= `CIB_KIND_CLEAN_INV;
      MSG_ADDR <= '0;
      barrier <= 1'b0;
    end
    else if (take)
    begin
      barrier <= 1'b0;
      MSG_ADDR <= '0;
      if (DC_FLUSH_REQ)
      begin
        MSG_KIND <= `CIB_KIND_CLEAN_INV;
        MSG_ADDR <= DC_PADDR;
      end
      else if (DC_CLEAR_REQ)
      begin
        MSG_KIND <= `CIB_KIND_MAKE_INV;
        MSG_ADDR <= DC_PADDR;
      end
      else if (IC_INV_REQ)
      begin
        MSG_KIND <= MMU_VIRTUAL ? `CIB_KIND_IC_INV_VA : `CIB_KIND_IC_INV_PA;
        MSG_ADDR <= MMU_VIRTUAL ? IC_VADDR : IC_PADDR;
      end
      else if (tlb_inv_req)
      begin
        // Any high-register write with TRANSLATION_HIGH_REG_VALID low is broadcast, present locally or not
        MSG_KIND <= `CIB_KIND_TLB_INV;
        MSG_ADDR <= TRANSLATION_HIGH_REG_VADDR;
      end
      else
      begin
        // Barrier also clears the branch target cache
        MSG_KIND <= `CIB_KIND_BTC_INV;
        barrier <= MEMORY_BARRIER_INSTR_REQ;
      end
    end
    else if (state == cib_pkg::CIB_TX_SEND && MSG_READY && barrier)
    begin
      MSG_KIND <= `CIB_KIND_SYNC;
      MSG_ADDR <= '0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      state <= cib_pkg::CIB_TX_IDLE;
    else
      case (state)
        cib_pkg::CIB_TX_IDLE:
          if (take)
            state <= cib_pkg::CIB_TX_SEND;
        cib_pkg::CIB_TX_SEND:
          if (MSG_READY)
            state <= barrier ? cib_pkg::CIB_TX_SYNC : cib_pkg::CIB_TX_IDLE;
        cib_pkg::CIB_TX_SYNC:
          if (MSG_READY)
            state <= cib_pkg::CIB_TX_WAIT;
        cib_pkg::CIB_TX_WAIT:
          if (SYNC_COMPLETE)
            state <= cib_pkg::CIB_TX_IDLE;
        default:
          state <= cib_pkg::CIB_TX_IDLE;
      endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      MSG_VALID <= 1'b0;
    else if (take)
      MSG_VALID <= 1'b1;
    else if (state == cib_pkg::CIB_TX_SEND && MSG_READY)
      MSG_VALID <= barrier;
    else if (state == cib_pkg::CIB_TX_SYNC && MSG_READY)
      MSG_VALID <= 1'b0;
  end

  // Busy from the take until the broadcast is retired
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      LOCAL_BUSY <= 1'b0;
    else if (take)
      LOCAL_BUSY <= 1'b1;
    else if ((state == cib_pkg::CIB_TX_SEND && MSG_READY && !barrier)
      || (state == cib_pkg::CIB_TX_WAIT && SYNC_COMPLETE))
      LOCAL_BUSY <= 1'b0;
  end

  // Without coherency a barrier needs no peers and retires at once
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
      MEMORY_BARRIER_INSTR_DONE <= 1'b0;
    else
      MEMORY_BARRIER_INSTR_DONE <= (state == cib_pkg::CIB_TX_WAIT && SYNC_COMPLETE)
        || (!COHERENT && MEMORY_BARRIER_INSTR_REQ);
  end

  assign rx_port.enable = COHERENT;
  assign rx_port.rx_valid = RX_VALID;
  assign rx_port.rx_kind = RX_KIND;
  assign rx_port.rx_addr = RX_ADDR;
  assign rx_port.loc_ack = LOC_ACK;
  assign rx_port.resp_ready = RESP_READY;
  assign RX_READY = rx_port.rx_ready;
  assign RESP_VALID = rx_port.resp_valid;
  assign LOC_DC_INV = rx_port.dc_inv;
  assign LOC_IC_INV = rx_port.ic_inv;
  assign LOC_TLB_INV = rx_port.tlb_inv;
  assign LOC_BTC_INV = rx_port.btc_inv;
  assign LOC_INV_ADDR = rx_port.inv_addr;

  cib_rx u_rx
  (
    .mclk(MCLK),
    .reset_n(RESET_N),
    .port(rx_port.applier)
  );
endmodule // cib_top

`default_nettype wire
